//--- core/wdt_counter.sv
// Prescaled watchdog count, advanced by one tick per low-frequency edge.
// Assumes i_tick is a single-cycle pulse on the system clock.
module wdt_counter
  import wdt_pkg::*;
(
  input  wire logic            i_clock,
  input  wire logic            i_reset_n,
  input  wire logic            i_tick,
  input  wire logic            i_clear,
  input  wire logic [4:0]      i_period_select,
  output wdt_pkg::wdt_count_t  o_count,
  output logic                 o_expire
);

  wdt_count_t last_count;

  assign last_count = wdt_last_count(i_period_select);

  // Count held at zero while cleared; wraps to zero on expiry
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_count  <= '0;
      o_expire <= 1'b0;
    end
    else if (i_clear)
    begin
      o_count  <= '0;
      o_expire <= 1'b0;
    end
    else if (i_tick && (o_count >= last_count))
    begin
      o_count  <= '0;
      o_expire <= 1'b1;
    end
    else
    begin
      o_count  <= i_tick ? o_count + 1'b1 : o_count;
      o_expire <= 1'b0;
    end
  end

endmodule

//--- core/wdt_pkg.sv
// Package for the sleep-aware watchdog: register map, field layout,
// reset values, mode codes and the prescale lookup.
// Assumes a 32-bit Avalon-MM register bus addressed in bytes.
package wdt_pkg;

  // Register byte offsets
  localparam logic [3:0] ADDR_WATCHDOG_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_WATCHDOG_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_WATCHDOG_COUNT   = 4'h8;

  // Control register field positions
  localparam int CTRL_SW_ENABLE_BIT = 0;
  localparam int CTRL_PERIOD_LSB    = 1;
  localparam int CTRL_PERIOD_MSB    = 5;

  // Status register field positions
  localparam int STAT_TIMEOUT_N_BIT   = 0;
  localparam int STAT_POWERDOWN_N_BIT = 1;
  localparam int STAT_RUNNING_BIT     = 2;
  localparam int STAT_ASLEEP_BIT      = 3;
  localparam int STAT_MODE_LSB        = 4;
  localparam int STAT_MODE_MSB        = 5;

  // Reset values
  localparam logic [4:0] PERIOD_SELECT_RESET   = 5'h0b;
  localparam logic       SW_ENABLE_RESET       = 1'b0;
  localparam logic [1:0] MODE_CFG_RESET        = 2'h0;

  // Watchdog mode configuration codes
  localparam logic [1:0] MODE_ALWAYS_DISABLED     = 2'h0;
  localparam logic [1:0] MODE_SOFTWARE_CONTROLLED = 2'h1;
  localparam logic [1:0] MODE_ACTIVE_AWAKE_ONLY   = 2'h2;
  localparam logic [1:0] MODE_ALWAYS_ACTIVE       = 2'h3;

  // Prescale: code 0 divides by 2**5, highest valid code gives 2**23
  localparam int         PRESCALE_MIN_LOG2  = 5;
  localparam logic [4:0] PERIOD_SELECT_MAX  = 5'h12;
  localparam int         COUNT_WIDTH        = 23;

  // Low-frequency oscillator rate that times the watchdog
  localparam int LF_OSC_HZ = 31000;

  typedef logic [COUNT_WIDTH-1:0] wdt_count_t;

  // Last count value before expiry for a period select code
  function automatic wdt_count_t wdt_last_count(input logic [4:0] sel);
    logic [4:0] code;
    code = (sel > PERIOD_SELECT_MAX) ? 5'h00 : sel;
    wdt_last_count = wdt_count_t'((24'h000001 << (code + 5'(PRESCALE_MIN_LOG2))) - 24'h000001);
  endfunction

endpackage

//--- core/wdt_sync.sv
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the input is a free-running or slow asynchronous level.
module wdt_sync
(
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  input  wire logic i_async,
  output logic      o_sync
);

  logic stage_one;

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      stage_one <= 1'b0;
      o_sync    <= 1'b0;
    end
    else
    begin
      stage_one <= i_async;
      o_sync    <= stage_one;
    end
  end

endmodule

//--- core/wdt_top.sv
// Sleep-aware watchdog: mode decode, clearing, sleep handling, status
// flags and an Avalon-MM register slave.
// Assumes the core, reset controller and oscillator logic share i_clock;
// the low-frequency oscillator arrives asynchronously on a pin.
//
// The address map and register access over Avalon-MM were chosen for this implementation.

// Overview of operation
// - Mode 01 follows software enable bit only
// - Sleep never changes software-controlled enable state
// - 11 always on, 10 awake only, 00 off
// - Five-bit period select, 1 ms to 256 s
// - Period select resets to about two seconds
// - Code zero divides 32, each step doubles
// - Count cleared by resets, events and disable
// - Sleep entry clears, then counting may resume
// - Wake-up clears count regardless of cause
// - Crystal clocks hold clear until start-up ends
// - Time-out asleep wakes instead of resetting
// - Sleep time-out updates timeout and powerdown flags
// - Oscillator divider change leaves count alone
// - Awake time-out without clear issues reset
// - Count timed by 31 kHz internal oscillator
module wdt_top
  import wdt_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  // Avalon-MM slave
  input  wire logic [3:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [3:0]  i_byteenable,
  input  wire logic [31:0] i_writedata,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  // Configuration word and oscillator
  input  wire logic [1:0]  i_watchdog_mode_cfg,
  input  wire logic        i_low_freq_internal_osc,
  input  wire logic        i_crystal_clock_mode,
  input  wire logic        i_osc_startup_timer,
  input  wire logic        i_osc_fail,
  // Core events
  input  wire logic        i_clear_watchdog_instruction,
  input  wire logic        i_sleep_enter,
  input  wire logic        i_sleep_exit,
  // Results
  output logic             o_watchdog_reset,
  output logic             o_wake_request,
  output logic             o_timeout_flag_n,
  output logic             o_powerdown_flag_n,
  output logic             o_watchdog_running
);

  typedef enum logic [0:0]
  {
    PS_AWAKE,
    PS_ASLEEP
  } wdt_power_state_t;

  wdt_power_state_t power_state;
  wdt_power_state_t next_power_state;

  // Power state decode shared by the enable, flag, request and status logic
  function automatic logic is_asleep(input wdt_power_state_t state);
    is_asleep = (state == PS_ASLEEP);
  endfunction

  logic [1:0]  watchdog_mode_cfg;
  logic        cfg_captured;
  logic [4:0]  period_select;
  logic        software_watchdog_enable;
  logic        osc_level;
  logic        osc_level_d;
  logic        watchdog_tick;
  logic        post_wake_hold;
  logic        startup_seen;
  logic        active;
  logic        count_clear;
  logic        expire;
  logic        request_pending;
  wdt_count_t  count;
  logic        bus_request;
  logic        bus_commit;
  logic [31:0] next_readdata;

  // Low-frequency oscillator pin into the clock domain
  wdt_sync u_osc_sync
  (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_async   (i_low_freq_internal_osc),
    .o_sync    (osc_level)
  );

  // Rising edge of the synchronised oscillator times each count step
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      osc_level_d <= 1'b0;
    else
      osc_level_d <= osc_level;
  end

  assign watchdog_tick = osc_level && !osc_level_d;

  // Configuration word captured once after reset release
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      watchdog_mode_cfg <= MODE_CFG_RESET;
      cfg_captured      <= 1'b0;
    end
    else if (!cfg_captured)
    begin
      watchdog_mode_cfg <= i_watchdog_mode_cfg;
      cfg_captured      <= 1'b1;
    end
  end

  // Power state follows the core's sleep entry and exit
  always_comb
  begin
    next_power_state = power_state;
    case (power_state)
      PS_AWAKE:
        if (i_sleep_enter)
          next_power_state = PS_ASLEEP;
      PS_ASLEEP:
        if (i_sleep_exit)
          next_power_state = PS_AWAKE;
      default:
        next_power_state = PS_AWAKE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      power_state <= PS_AWAKE;
    else
      power_state <= next_power_state;
  end

  // Enable decode from the mode field, software bit and power state
  always_comb
  begin
    case (watchdog_mode_cfg)
      MODE_ALWAYS_ACTIVE:
        active = cfg_captured;
      MODE_ACTIVE_AWAKE_ONLY:
        active = cfg_captured && !is_asleep(power_state);
      MODE_SOFTWARE_CONTROLLED:
        active = cfg_captured && software_watchdog_enable;
      MODE_ALWAYS_DISABLED:
        active = 1'b0;
      default:
        active = 1'b0;
    endcase
  end

  // After wake-up on a crystal clock, hold clear until start-up ends
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      post_wake_hold <= 1'b0;
      startup_seen   <= 1'b0;
    end
    else if (is_asleep(power_state) && i_sleep_exit && i_crystal_clock_mode)
    begin
      post_wake_hold <= 1'b1;
      startup_seen   <= i_osc_startup_timer;
    end
    else if (post_wake_hold)
    begin
      startup_seen <= startup_seen || i_osc_startup_timer;
      if (startup_seen && !i_osc_startup_timer)
        post_wake_hold <= 1'b0;
    end
  end

  // Every clearing source; divider changes are not among them
  assign count_clear = !active
                     || i_clear_watchdog_instruction
                     || i_sleep_enter
                     || i_sleep_exit
                     || i_osc_fail
                     || i_osc_startup_timer
                     || post_wake_hold;

  wdt_counter u_counter
  (
    .i_clock         (i_clock),
    .i_reset_n       (i_reset_n),
    .i_tick          (watchdog_tick),
    .i_clear         (count_clear),
    .i_period_select (period_select),
    .o_count         (count),
    .o_expire        (expire)
  );

  // Reset or wake request held for one watchdog clock after expiry
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_watchdog_reset <= 1'b0;
      o_wake_request   <= 1'b0;
      request_pending  <= 1'b0;
    end
    else if (expire)
    begin
      request_pending <= 1'b1;
      if (is_asleep(power_state))
        o_wake_request <= 1'b1;
      else
        o_watchdog_reset <= 1'b1;
    end
    else if (request_pending && watchdog_tick)
    begin
      request_pending  <= 1'b0;
      o_watchdog_reset <= 1'b0;
      o_wake_request   <= 1'b0;
    end
  end

  // Status flags, active low; a time-out wins over any same-cycle set
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_timeout_flag_n   <= 1'b1;
      o_powerdown_flag_n <= 1'b1;
    end
    else if (expire)
    begin
      o_timeout_flag_n <= 1'b0;
      if (!is_asleep(power_state))
        o_powerdown_flag_n <= 1'b1;
      else
        o_powerdown_flag_n <= 1'b0;
    end
    else if (!is_asleep(power_state) && i_sleep_enter)
    begin
      o_timeout_flag_n   <= 1'b1;
      o_powerdown_flag_n <= 1'b0;
    end
    else if (i_clear_watchdog_instruction)
    begin
      o_timeout_flag_n   <= 1'b1;
      o_powerdown_flag_n <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_watchdog_running <= 1'b0;
    else
      o_watchdog_running <= active && !count_clear;
  end

  // Bus handshake: one wait cycle, then the access completes
  assign bus_request = i_read || i_write;
  assign bus_commit  = bus_request && !o_waitrequest;

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_waitrequest <= 1'b1;
    else if (bus_request && o_waitrequest)
      o_waitrequest <= 1'b0;
    else
      o_waitrequest <= 1'b1;
  end

  // Control register writes; lane zero holds every writable bit
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      period_select            <= PERIOD_SELECT_RESET;
      software_watchdog_enable <= SW_ENABLE_RESET;
    end
    else if (bus_commit && i_write && i_byteenable[0]
             && i_address == ADDR_WATCHDOG_CONTROL)
    begin
      period_select            <= i_writedata[CTRL_PERIOD_MSB:CTRL_PERIOD_LSB];
      software_watchdog_enable <= i_writedata[CTRL_SW_ENABLE_BIT];
    end
  end

  // Read mux; unmapped offsets and reserved bits read as zero
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    case (i_address)
      ADDR_WATCHDOG_CONTROL:
      begin
        next_readdata[CTRL_PERIOD_MSB:CTRL_PERIOD_LSB] = period_select;
        next_readdata[CTRL_SW_ENABLE_BIT]              = software_watchdog_enable;
      end
      ADDR_WATCHDOG_STATUS:
      begin
        next_readdata[STAT_TIMEOUT_N_BIT]          = o_timeout_flag_n;
        next_readdata[STAT_POWERDOWN_N_BIT]        = o_powerdown_flag_n;
        next_readdata[STAT_RUNNING_BIT]            = o_watchdog_running;
        next_readdata[STAT_ASLEEP_BIT]             = is_asleep(power_state);
        next_readdata[STAT_MODE_MSB:STAT_MODE_LSB] = watchdog_mode_cfg;
      end
      ADDR_WATCHDOG_COUNT:
        next_readdata[COUNT_WIDTH-1:0] = count;
      default:
        next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_readdata <= 32'h0000_0000;
    else if (i_read && o_waitrequest)
      o_readdata <= next_readdata;
  end

endmodule

//--- dv/wdt_osc_model.sv
// Partner model: the free-running low-frequency oscillator pin.
// Assumes nothing of the bench; phase is unrelated to the system clock.
module wdt_osc_model
#(
  parameter int HALF_NS = 47
)
(
  output logic o_osc
);
  timeunit 1ns;
  timeprecision 1ps;

  // Free-running source that times the watchdog
  initial
  begin
    o_osc = 1'b0;
    forever #(HALF_NS) o_osc = ~o_osc;
  end
endmodule

//--- dv/wdt_props.sv
// Checker for the watchdog top ports.
// Assumes one clock domain and an oscillator tick every 9 to 10 clocks.
module wdt_props
(
  input wire logic       i_clock,
  input wire logic       i_reset_n,
  input wire logic       i_read,
  input wire logic       i_write,
  input wire logic       o_waitrequest,
  input wire logic [1:0] i_watchdog_mode_cfg,
  input wire logic       i_osc_startup_timer,
  input wire logic       i_clear_watchdog_instruction,
  input wire logic       i_sleep_enter,
  input wire logic       i_sleep_exit,
  input wire logic       o_watchdog_reset,
  input wire logic       o_wake_request,
  input wire logic       o_timeout_flag_n,
  input wire logic       o_powerdown_flag_n,
  input wire logic       o_watchdog_running
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  property p_mode_off;
    i_watchdog_mode_cfg == 2'h0 |-> !o_watchdog_running;
  endproperty
  property p_awake_only;
    i_watchdog_mode_cfg == 2'h2 |-> !o_wake_request;
  endproperty
  property p_startup_clear;
    i_osc_startup_timer |=> !o_watchdog_running;
  endproperty
  property p_clear_instr;
    i_clear_watchdog_instruction |=> !o_watchdog_running;
  endproperty
  property p_exit_clear;
    i_sleep_exit |=> !o_watchdog_running;
  endproperty
  property p_reset_flags;
    $rose(o_watchdog_reset) |-> !o_timeout_flag_n && o_powerdown_flag_n && !o_wake_request;
  endproperty
  property p_wake_flags;
    $rose(o_wake_request) |-> !o_timeout_flag_n && !o_powerdown_flag_n && !o_watchdog_reset;
  endproperty
  property p_enter_flags;
    i_sleep_enter |=> o_timeout_flag_n && !o_powerdown_flag_n;
  endproperty
  property p_pulse_len;
    $rose(o_watchdog_reset) |-> o_watchdog_reset[*8] ##[1:12] !o_watchdog_reset;
  endproperty
  property p_bus_answer;
    (i_read || i_write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest;
  endproperty

  a_mode_off: assert property (p_mode_off) else $error("mode off but running");
  a_awake_only: assert property (p_awake_only) else $error("wake in awake mode");
  a_startup_clear: assert property (p_startup_clear) else $error("startup no clear");
  a_clear_instr: assert property (p_clear_instr) else $error("clear not applied");
  a_exit_clear: assert property (p_exit_clear) else $error("exit not cleared");
  a_reset_flags: assert property (p_reset_flags) else $error("reset flags wrong");
  a_wake_flags: assert property (p_wake_flags) else $error("wake flags wrong");
  a_enter_flags: assert property (p_enter_flags) else $error("sleep flags wrong");
  a_pulse_len: assert property (p_pulse_len) else $error("request length wrong");
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer wrong");

  c_reset: cover property ($rose(o_watchdog_reset));
  c_wake: cover property ($rose(o_wake_request));
  c_read: cover property (i_read && !o_waitrequest);
endmodule

bind wdt_top wdt_props i_wdt_props (.i_clock, .i_reset_n, .i_read, .i_write, .o_waitrequest,
  .i_watchdog_mode_cfg, .i_osc_startup_timer, .i_clear_watchdog_instruction, .i_sleep_enter,
  .i_sleep_exit, .o_watchdog_reset, .o_wake_request, .o_timeout_flag_n, .o_powerdown_flag_n,
  .o_watchdog_running);

//--- dv/wdt_tb_top.sv
// Testbench for the sleep-aware watchdog: bus tasks and mode scenarios.
// Assumes the oscillator model drives the low-frequency pin.
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module wdt_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import wdt_pkg::*;

  logic        i_clock, i_reset_n, i_read, i_write, saw_rst;
  logic [3:0]  i_address, i_byteenable;
  logic [31:0] i_writedata, o_readdata, rd;
  logic        o_waitrequest, i_low_freq_internal_osc, i_crystal_clock_mode;
  logic        i_osc_startup_timer, i_osc_fail, i_clear_watchdog_instruction;
  logic        i_sleep_enter, i_sleep_exit, o_watchdog_reset, o_wake_request;
  logic        o_timeout_flag_n, o_powerdown_flag_n, o_watchdog_running;
  logic [1:0]  i_watchdog_mode_cfg;
  int          errors, compares, ticks, t0;
  logic [4:0]  sel_tab[4] = '{5'h00, 5'h01, 5'h02, 5'h13};
  int          exp_tab[4] = '{32, 64, 128, 32};

  wdt_osc_model i_wdt_osc_model (.o_osc(i_low_freq_internal_osc));
  wdt_top i_wdt_top (.i_clock, .i_reset_n, .i_address, .i_read, .i_write, .i_byteenable,
    .i_writedata, .o_readdata, .o_waitrequest, .i_watchdog_mode_cfg, .i_low_freq_internal_osc,
    .i_crystal_clock_mode, .i_osc_startup_timer, .i_osc_fail, .i_clear_watchdog_instruction,
    .i_sleep_enter, .i_sleep_exit, .o_watchdog_reset, .o_wake_request, .o_timeout_flag_n,
    .o_powerdown_flag_n, .o_watchdog_running);

  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_low_freq_internal_osc) ticks++;
  always @(posedge i_clock) if (o_watchdog_reset === 1'b1) saw_rst = 1'b1;

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_write <= w;
    i_read <= !w;
    i_address <= a;
    i_writedata <= d;
    do @(posedge i_clock); while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask

  // Event pulse: 0 clear, 1 sleep entry, 2 sleep exit, 3 oscillator failure
  task automatic ev(input int k);
    @(posedge i_clock);
    case (k)
      0: i_clear_watchdog_instruction <= 1'b1;
      1: i_sleep_enter <= 1'b1;
      2: i_sleep_exit <= 1'b1;
      default: i_osc_fail <= 1'b1;
    endcase
    @(posedge i_clock);
    {i_clear_watchdog_instruction, i_sleep_enter, i_sleep_exit, i_osc_fail} <= 4'h0;
  endtask

  task automatic expire(input int lim);
    t0 = ticks;
    repeat (lim) if (o_watchdog_reset !== 1'b1 && o_wake_request !== 1'b1) @(posedge i_clock);
    t0 = ticks - t0;
  endtask

  task automatic do_reset(input logic [1:0] cfg);
    @(posedge i_clock);
    i_reset_n <= 1'b0;
    i_watchdog_mode_cfg <= cfg;
    repeat (3) @(posedge i_clock);
    i_reset_n <= 1'b1;
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #300us;
    errors++;
    print_verdict;
  end

  initial
  begin
    {i_read, i_write, i_osc_fail, i_clear_watchdog_instruction} = 4'h0;
    {i_sleep_enter, i_sleep_exit, i_crystal_clock_mode, i_osc_startup_timer} = 4'h0;
    {i_address, i_writedata, i_byteenable} = {4'h0, 32'h0, 4'hf};
    i_reset_n = 1'b0;
    i_watchdog_mode_cfg = MODE_SOFTWARE_CONTROLLED;
    repeat (3) @(posedge i_clock);
    i_reset_n <= 1'b1;
    bus(0, ADDR_WATCHDOG_CONTROL, 0);
    `CHK("control reset", 32'h00000016, rd)
    bus(0, 4'hc, 0);
    `CHK("unmapped read", 32'h0, rd)
    bus(1, ADDR_WATCHDOG_STATUS, 0);
    bus(0, ADDR_WATCHDOG_STATUS, 0);
    `CHK("status flags", 6'h13, rd[5:0])
    bus(1, ADDR_WATCHDOG_CONTROL, 32'hffffffff);
    bus(0, ADDR_WATCHDOG_CONTROL, 0);
    `CHK("control mask", 32'h0000003f, rd)
    i_byteenable <= 4'he;
    bus(1, ADDR_WATCHDOG_CONTROL, 0);
    i_byteenable <= 4'hf;
    bus(0, ADDR_WATCHDOG_CONTROL, 0);
    `CHK("lane zero off", 32'h0000003f, rd)
    bus(1, ADDR_WATCHDOG_CONTROL, 0);
    expire(400);
    `CHK("soft off reset", 1'b0, o_watchdog_reset)
    foreach (sel_tab[j])
    begin
      bus(1, ADDR_WATCHDOG_CONTROL, {26'h0, sel_tab[j], 1'b1});
      expire(2000);
      `CHK("period reset", 1'b1, o_watchdog_reset)
      `CHK("period ticks", 1'b1, (t0 >= exp_tab[j] - 1 && t0 <= exp_tab[j] + 1))
      bus(1, ADDR_WATCHDOG_CONTROL, 0);
      repeat (20) @(posedge i_clock);
    end
    bus(1, ADDR_WATCHDOG_CONTROL, 1);
    saw_rst = 1'b0;
    repeat (8)
    begin
      repeat (150) @(posedge i_clock);
      ev(0);
    end
    `CHK("cleared no reset", 1'b0, saw_rst)
    repeat (100) @(posedge i_clock);
    ev(3);
    bus(0, ADDR_WATCHDOG_COUNT, 0);
    `CHK("fail clears", 1'b1, rd < 2)
    @(posedge i_clock);
    i_osc_startup_timer <= 1'b1;
    repeat (50) @(posedge i_clock);
    bus(0, ADDR_WATCHDOG_COUNT, 0);
    `CHK("startup count", 32'h0, rd)
    `CHK("startup running", 1'b0, o_watchdog_running)
    i_osc_startup_timer <= 1'b0;
    ev(1);
    bus(0, ADDR_WATCHDOG_STATUS, 0);
    `CHK("sleep flags", 2'b01, rd[1:0])
    expire(600);
    `CHK("sleep wake", 1'b1, o_wake_request)
    `CHK("sleep no reset", 1'b0, o_watchdog_reset)
    bus(0, ADDR_WATCHDOG_STATUS, 0);
    `CHK("wake flags", 2'b00, rd[1:0])
    repeat (100) @(posedge i_clock);
    ev(2);
    bus(0, ADDR_WATCHDOG_COUNT, 0);
    `CHK("exit clears", 1'b1, rd < 2)
    @(posedge i_clock);
    i_crystal_clock_mode <= 1'b1;
    ev(1);
    ev(2);
    repeat (100) @(posedge i_clock);
    bus(0, ADDR_WATCHDOG_COUNT, 0);
    `CHK("crystal hold", 32'h0, rd)
    i_osc_startup_timer <= 1'b1;
    repeat (5) @(posedge i_clock);
    i_osc_startup_timer <= 1'b0;
    repeat (100) @(posedge i_clock);
    bus(0, ADDR_WATCHDOG_COUNT, 0);
    `CHK("crystal release", 1'b1, rd > 0)
    i_crystal_clock_mode <= 1'b0;
    do_reset(MODE_ACTIVE_AWAKE_ONLY);
    bus(1, ADDR_WATCHDOG_CONTROL, 0);
    repeat (30) @(posedge i_clock);
    `CHK("awake running", 1'b1, o_watchdog_running)
    ev(1);
    expire(600);
    `CHK("asleep no wake", 1'b0, o_wake_request)
    ev(2);
    do_reset(MODE_ALWAYS_DISABLED);
    bus(1, ADDR_WATCHDOG_CONTROL, 1);
    expire(600);
    `CHK("off no reset", 1'b0, o_watchdog_reset)
    do_reset(MODE_ALWAYS_ACTIVE);
    bus(1, ADDR_WATCHDOG_CONTROL, 0);
    expire(600);
    `CHK("on reset", 1'b1, o_watchdog_reset)
    repeat (20) @(posedge i_clock);
    ev(1);
    expire(600);
    `CHK("on sleep wake", 1'b1, o_wake_request)
    print_verdict;
  end
endmodule
